// >>> verification/fm_host_model.sv
// Purpose: host that answers the interrupt by clearing every sticky bit it sees
// Assumes: sticky clear is a one-cycle strobe with the bit vector beside it
// Notes: dly_in sets how slowly the host reacts, 0 answers at once
`timescale 1ns/1ps
module fm_host_model (
  input wire logic clk_sys_in,            // System clock
  input wire logic rstn_in,               // Synchronous reset, active low
  input wire logic en_in,                 // Host servicing enabled
  input wire logic [3:0] dly_in,          // Reaction delay in cycles
  input wire logic irq_in_n,              // Interrupt from the block
  input wire logic [6:0] sticky_in,       // Sticky status read back
  output logic [6:0] clr_out,             // Bits to clear
  output logic clr_stb_out                // Clear write strobe
);
  logic [3:0] wait_cnt;

  // Clear all sticky bits while the interrupt is low; a bit whose
  // live cause stands stays set, so the host may retry harmlessly
  always_ff @(posedge clk_sys_in) begin
    clr_stb_out <= 1'b0;
    if (!rstn_in || !en_in || irq_in_n) begin
      wait_cnt <= 4'h0;
      clr_out <= 7'h00;
    end else if (wait_cnt >= dly_in && !clr_stb_out) begin
      clr_out <= sticky_in;
      clr_stb_out <= 1'b1;
      wait_cnt <= 4'h0;
    end else begin
      clr_out <= ~clr_out; // Vector is meaningless outside the strobe
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// >>> verification/fm_mon_top_test.sv
// Purpose: self-checking bench of the clock fault monitor
// Assumes: TICK_CYC of 10, so one delay unit is 10 cycles
// Notes: expected values follow from thresholds set here
`timescale 1ns/1ps
module fm_mon_top_test;
  import fm_pkg::*;
  logic clk_sys_in, rstn_in, prec_stb, fast_stb, lol_stb, xpt_wr, host_en, casc;
  logic clr_stb, pa, pc, pd, pr, irq_n, casc_o, over;
  fm_oof_cfg_t oof_cfg;
  fm_lol_cfg_t lol_cfg [4];
  logic signed [OFS_W-1:0] prec_ofs [4];
  logic signed [OFS_W-1:0] fast_ofs [4];
  logic [LOL_W-1:0] lol_diff [4];
  logic [N_IND-1:0] clr, mask, sticky;
  logic [1:0] nvm [7];
  logic [1:0] sel [7];
  logic [1:0] route [7];
  logic [1:0] exp_rt [7];
  logic [N_DRV-1:0] se, se_o;
  logic [15:0] khz;
  logic [3:0] host_dly, pairs, lol_live;
  logic [2:0] oof_live;
  int bad_count, total_checks;

  fm_mon_top #(.TICK_CYC(10)) dut_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .oof_cfg_in(oof_cfg), .prec_ofs_in(prec_ofs), .prec_stb_in(prec_stb),
    .fast_ofs_in(fast_ofs), .fast_stb_in(fast_stb), .lol_cfg_in(lol_cfg),
    .lol_diff_in(lol_diff), .lol_stb_in(lol_stb), .sticky_clr_in(clr),
    .sticky_clr_stb_in(clr_stb), .irq_mask_in(mask), .xpt_nvm_in(nvm),
    .xpt_sel_in(sel), .xpt_wr_in(xpt_wr), .drv_se_in(se), .casc_1hz_in(casc),
    .out5_khz_in(khz), .oof_live_out(oof_live), .sticky_out(sticky),
    .lol_live_out(lol_live), .unlock_pin_loop_a_n_out(pa),
    .unlock_pin_loop_c_n_out(pc), .unlock_pin_loop_d_n_out(pd),
    .unlock_pin_n_out(pr), .irq_out_n(irq_n), .xpt_route_out(route),
    .drv_se_out(se_o), .se_pairs_out(pairs), .casc_1hz_out(casc_o),
    .out5_over_out(over));

  fm_host_model host_u (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .en_in(host_en),
    .dly_in(host_dly), .irq_in_n(irq_n), .sticky_in(sticky), .clr_out(clr),
    .clr_stb_out(clr_stb));

  // Free-running 10 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Land just after an edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // Caller sets data at an edge; pulse one strobe, return 2 edges after it is taken
  task automatic strobe(input int k);
    case (k)
      0: prec_stb <= 1'b1;
      1: fast_stb <= 1'b1;
      2: lol_stb <= 1'b1;
      default: xpt_wr <= 1'b1;
    endcase
    @(posedge clk_sys_in);
    {prec_stb, fast_stb, lol_stb, xpt_wr} <= 4'h0;
    wt(2);
  endtask

  task automatic t_reset;
    wt(4);
    chk("lol_live", 4'hf, lol_live);
    chk("pins", 4'h0, {pa, pc, pd, pr});
    chk("sticky", 7'h78, sticky);
    chk("irq", 1'b0, irq_n);
    for (int i = 0; i < 7; i++) chk("route", nvm[i], route[i]);
    $display("reset test done");
  endtask

  task automatic t_xpt;
    @(posedge clk_sys_in);
    sel <= '{2'h2, 2'h2, 2'h1, 2'h3, 2'h0, 2'h0, 2'h0};
    exp_rt = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
    se <= 7'h55;
    casc <= 1'b1;
    khz <= 16'h82dd;
    strobe(3);
    for (int i = 0; i < 7; i++) chk("route", exp_rt[i], route[i]);
    chk("drv_se", 7'h55, se_o);
    chk("pairs", 4'h4, pairs);
    chk("casc", 1'b1, casc_o);
    chk("over", 1'b1, over);
    @(posedge clk_sys_in);
    khz <= 16'h82dc;
    wt(2);
    chk("over", 1'b0, over);
    $display("crosspoint test done");
  endtask

  // Loop C goes above set threshold, others sit between the two
  task automatic t_lock;
    @(posedge clk_sys_in);
    lol_diff <= '{17'd5, 17'd5, 17'd5, 17'd5};
    strobe(2);
    chk("lol_live", 4'h0, lol_live);
    chk("pins", 4'hf, {pa, pc, pd, pr});
    @(posedge clk_sys_in);
    lol_diff <= '{17'd15, 17'd21, 17'd15, 17'd20};
    strobe(2);
    chk("lol_live", 4'h2, lol_live);
    chk("pins", 4'hb, {pa, pc, pd, pr});
    @(posedge clk_sys_in);
    lol_diff <= '{17'd5, 17'd5, 17'd5, 17'd5};
    host_dly <= 4'h3;
    host_en <= 1'b1;
    strobe(2);
    wt(10);
    chk("sticky", 7'h00, sticky);
    chk("irq", 1'b1, irq_n);
    $display("lock test done");
  endtask

  task automatic t_freq;
    @(posedge clk_sys_in);
    host_dly <= 4'h0;
    oof_cfg <= '{1'b1, 1'b0, 13'h0064, 13'h001e, FM_REF_PIN};
    prec_ofs <= '{24'sd0, 24'sd100, 24'sd0, 24'sd0};
    strobe(0);
    chk("oof", 3'h0, oof_live);
    @(posedge clk_sys_in);
    prec_ofs[1] <= 24'sd101;
    strobe(0);
    chk("oof", 3'h1, oof_live);
    wt(8);
    chk("sticky", 7'h01, sticky);
    chk("irq", 1'b0, irq_n);
    @(posedge clk_sys_in);
    prec_ofs[1] <= 24'sd71;
    strobe(0);
    chk("oof", 3'h1, oof_live);
    @(posedge clk_sys_in);
    prec_ofs[1] <= 24'sd70;
    strobe(0);
    chk("oof", 3'h0, oof_live);
    wt(8);
    chk("sticky", 7'h00, sticky);
    $display("precise test done");
  endtask

  task automatic t_fast;
    @(posedge clk_sys_in);
    oof_cfg.fast_en <= 1'b1;
    fast_ofs <= '{24'sd0, 24'sd0, 24'sd64001, -24'sd64001};
    strobe(1);
    chk("oof", 3'h6, oof_live);
    @(posedge clk_sys_in);
    fast_ofs <= '{24'sd0, 24'sd64001, 24'sd64000, -24'sd64000};
    strobe(1);
    chk("oof", 3'h1, oof_live);
    @(posedge clk_sys_in);
    oof_cfg.fast_en <= 1'b0;
    wt(3);
    chk("oof", 3'h0, oof_live);
    $display("fast test done");
  endtask

  // Every reference choice against fixed offsets, no hysteresis
  task automatic t_refsel;
    int v [4];
    int r;
    int d;
    logic [2:0] e;
    v = '{300, 0, 150, 600};
    for (int s = 0; s < 5; s++) begin
      @(posedge clk_sys_in);
      oof_cfg <= '{1'b1, 1'b0, 13'h0064, 13'h0000, fm_ref_sel_t'(s)};
      prec_ofs <= '{24'(v[0]), 24'(v[1]), 24'(v[2]), 24'(v[3])};
      strobe(0);
      r = (s == 0) ? v[0] : (s < 4) ? v[s] : 0;
      for (int i = 0; i < 3; i++) begin
        d = v[i + 1] - r;
        e[i] = (d > 100) || (d < -100);
      end
      chk("oof", e, oof_live);
    end
    $display("reference test done");
  endtask

  task automatic t_mask;
    @(posedge clk_sys_in);
    prec_ofs <= '{24'sd0, 24'sd0, 24'sd0, 24'sd0};
    strobe(0);
    wt(8);
    @(posedge clk_sys_in);
    mask <= 7'h02;
    prec_ofs[2] <= 24'sd200;
    strobe(0);
    wt(4);
    chk("sticky", 7'h02, sticky);
    chk("irq", 1'b1, irq_n);
    @(posedge clk_sys_in);
    prec_ofs[2] <= 24'sd0;
    mask <= 7'h00;
    strobe(0);
    wt(8);
    chk("sticky", 7'h00, sticky);
    chk("irq", 1'b1, irq_n);
    $display("mask test done");
  endtask

  // Three delay units of 10 cycles; the first may come one unit early
  task automatic t_delay;
    @(posedge clk_sys_in);
    lol_cfg[0] <= '{17'd20, 17'd10, 1'b1, 16'h0003};
    lol_diff[0] <= 17'd30;
    strobe(2);
    chk("lol_live", 4'h1, lol_live);
    @(posedge clk_sys_in);
    lol_diff[0] <= 17'd5;
    strobe(2);
    wt(13);
    chk("lol_live", 4'h1, lol_live);
    wt(30);
    chk("lol_live", 4'h0, lol_live);
    // Zero thresholds clamp to one step, so a difference of one stays locked
    @(posedge clk_sys_in);
    lol_cfg[3] <= '{17'd0, 17'd0, 1'b0, 16'h0000};
    lol_diff[3] <= 17'd1;
    strobe(2);
    chk("lol_live", 4'h0, lol_live);
    $display("delay test done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    bad_count = 0;
    total_checks = 0;
    rstn_in = 1'b0;
    {prec_stb, fast_stb, lol_stb, xpt_wr, host_en, casc} = 6'h00;
    host_dly = 4'h0;
    oof_cfg = '{1'b0, 1'b0, 13'h0064, 13'h0000, FM_REF_PIN};
    for (int i = 0; i < 4; i++) lol_cfg[i] = '{17'd20, 17'd10, 1'b0, 16'h0000};
    prec_ofs = '{24'sd0, 24'sd0, 24'sd0, 24'sd0};
    fast_ofs = '{24'sd0, 24'sd0, 24'sd0, 24'sd0};
    lol_diff = '{17'd30, 17'd30, 17'd30, 17'd30};
    mask = 7'h00;
    nvm = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h0};
    sel = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    se = 7'h00;
    khz = 16'h0000;
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    t_reset;
    t_xpt;
    t_lock;
    t_freq;
    t_fast;
    t_refsel;
    t_mask;
    t_delay;
    test_done;
  end
endmodule

// >>> verilog/fm_lol_mon.sv
// Purpose: loss-of-lock monitor for one synthesis loop
// Assumes: diff_in is the phase detector frequency difference, 0.1 ppm units
// Notes: set and clear comparators differ, giving hysteresis
`timescale 1ns/1ps
module fm_lol_mon (
  input logic clk_sys_in,                  // System clock
  input logic rstn_in,                     // Synchronous reset, active low
  input logic [fm_pkg::LOL_W-1:0] diff_in, // Measured difference
  input logic stb_in,                      // Difference valid pulse
  input fm_pkg::fm_lol_cfg_t cfg_in,       // Thresholds and delay
  input logic tick_in,                     // Delay time unit enable
  output logic lol_out                     // Live loss of lock
);
  import fm_pkg::*;
  typedef enum logic [1:0] {ST_UNLOCK, ST_WAIT, ST_LOCK} fm_lol_st_t;
  fm_lol_st_t st;
  fm_lol_st_t next_st;
  logic [15:0] cnt;
  // Comparators against clamped thresholds
  wire [LOL_W-1:0] set_t = fm_lol_clamp(cfg_in.set_thr);
  wire [LOL_W-1:0] clr_t = fm_lol_clamp(cfg_in.clr_thr);
  wire over = stb_in && (diff_in > set_t);
  wire under = stb_in && (diff_in < clr_t);
  wire back = stb_in && !under;
  wire use_dly = cfg_in.dly_en && (cfg_in.dly_ms != 16'h0);
  wire expired = tick_in && (cnt == 16'h1);

  // Set wins; clear waits for the optional timer
  always_comb begin
    next_st = st;
    case (st)
      ST_LOCK: next_st = over ? ST_UNLOCK : ST_LOCK;
      ST_UNLOCK: begin
        if (under && !over) begin
          next_st = use_dly ? ST_WAIT : ST_LOCK;
        end
      end
      ST_WAIT: begin
        if (over || back) begin
          next_st = ST_UNLOCK;
        end else if (expired) begin
          next_st = ST_LOCK;
        end
      end
      default: next_st = ST_UNLOCK;
    endcase
  end

  // State, timer and live indicator
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      st <= ST_UNLOCK;
      cnt <= 16'h0;
      lol_out <= LOL_RST;
    end else begin
      st <= next_st;
      if (st != ST_WAIT) begin
        cnt <= cfg_in.dly_ms;
      end else if (tick_in) begin
        cnt <= cnt - 16'h1;
      end
      lol_out <= (next_st != ST_LOCK);
    end
  end

  property p_lol_set;
    @(posedge clk_sys_in) disable iff (!rstn_in) over |=> lol_out;
  endproperty
  a_lol_set: assert property (p_lol_set)
    else $error("lock loss not raised above set threshold");

  property p_lol_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (st == ST_WAIT && cnt != 16'h1) |=> lol_out;
  endproperty
  a_lol_hold: assert property (p_lol_hold)
    else $error("lock loss cleared before delay ran out");

  property p_lol_fast_clr;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (st == ST_UNLOCK && under && !over && !use_dly) |=> !lol_out;
  endproperty
  a_lol_fast_clr: assert property (p_lol_fast_clr)
    else $error("lock loss not cleared below clear threshold");
endmodule

// >>> verilog/fm_mon_top.sv
// Purpose: input frequency and loop lock status monitor with interrupt
// Assumes: measurement front end delivers offsets on the system clock
// Notes: offsets are versus the crystal, signed, 1/16 ppm units
//
// Notes on behaviour
// - Check three inputs against one selected reference
// - Final status combines precise and fast monitors
// - Frequency status has live and sticky bits
// - Precise monitor resolves one sixteenth ppm
// - Window up to 500 ppm, sixteenth steps
// - Programmable hysteresis between assert and deassert
// - Reference is pin, any input, or crystal
// - Fast monitor flags moves beyond 4000 ppm
// - Each loop has its own lock monitor
// - Active-low unlock pin per loop and reference
// - Separate set and clear lock comparators
// - Lock thresholds programmable 0.1 to 10000 ppm
// - Optional timer delays lock loss clearing
// - Lock loss has live and sticky bits
// - Interrupt asserts while any unmasked sticky indicator is set
// - Each indicator has its own mask
// - Interrupt releases when sticky bits are cleared
// - Crosspoint routes each driver to loop selection 0, 1 or 2
// - Seven drivers, differential or single-ended pair
// - Cascade gives 1 Hz, neighbour limited 33.5 MHz
`timescale 1ns/1ps
module fm_mon_top #(
  parameter int TICK_CYC = fm_pkg::LOL_TICK_CYC
) (
  input logic clk_sys_in,                                   // System clock
  input logic rstn_in,                                      // Sync reset, low
  input fm_pkg::fm_oof_cfg_t oof_cfg_in,                    // Freq config
  input logic signed [fm_pkg::OFS_W-1:0] prec_ofs_in [4],   // Ref pin, in0..2
  input logic prec_stb_in,                                  // Precise round done
  input logic signed [fm_pkg::OFS_W-1:0] fast_ofs_in [4],   // Coarse offsets
  input logic fast_stb_in,                                  // Coarse round done
  input fm_pkg::fm_lol_cfg_t lol_cfg_in [4],                // Loops a, c, d, ref
  input logic [fm_pkg::LOL_W-1:0] lol_diff_in [4],          // Detector diffs
  input logic lol_stb_in,                                   // Diffs valid
  input logic [fm_pkg::N_IND-1:0] sticky_clr_in,            // Clear bits
  input logic sticky_clr_stb_in,                            // Clear write
  input logic [fm_pkg::N_IND-1:0] irq_mask_in,              // 1 masks
  input logic [1:0] xpt_nvm_in [7],                         // Power-up routing
  input logic [1:0] xpt_sel_in [7],                         // New routing
  input logic xpt_wr_in,                                    // Routing write
  input logic [fm_pkg::N_DRV-1:0] drv_se_in,                // 1 single-ended
  input logic casc_1hz_in,                                  // 1 Hz cascade
  input logic [15:0] out5_khz_in,                           // Neighbour freq
  output logic [fm_pkg::N_IN-1:0] oof_live_out,             // Live freq fault
  output logic [fm_pkg::N_IND-1:0] sticky_out,              // Sticky status
  output logic [fm_pkg::N_LOOP-1:0] lol_live_out,           // Live lock loss
  output logic unlock_pin_loop_a_n_out,                     // Loop a pin
  output logic unlock_pin_loop_c_n_out,                     // Loop c pin
  output logic unlock_pin_loop_d_n_out,                     // Loop d pin
  output logic unlock_pin_n_out,                            // Reference pin
  output logic irq_out_n,                                   // Interrupt, low
  output logic [1:0] xpt_route_out [7],                     // Driver source
  output logic [fm_pkg::N_DRV-1:0] drv_se_out,              // Driver format
  output logic [3:0] se_pairs_out,                          // Single-ended count
  output logic casc_1hz_out,                                // Cascade active
  output logic out5_over_out                                // Neighbour too fast
);
  import fm_pkg::*;

  // Reference offset selection; crystal is the zero of the offsets
  logic signed [OFS_W-1:0] ref_prec;
  logic signed [OFS_W-1:0] ref_fast;
  always_comb begin
    case (oof_cfg_in.ref_sel)
      FM_REF_PIN: begin
        ref_prec = prec_ofs_in[0];
        ref_fast = fast_ofs_in[0];
      end
      FM_REF_IN0: begin
        ref_prec = prec_ofs_in[1];
        ref_fast = fast_ofs_in[1];
      end
      FM_REF_IN1: begin
        ref_prec = prec_ofs_in[2];
        ref_fast = fast_ofs_in[2];
      end
      FM_REF_IN2: begin
        ref_prec = prec_ofs_in[3];
        ref_fast = fast_ofs_in[3];
      end
      default: begin
        ref_prec = '0;
        ref_fast = '0;
      end
    endcase
  end

  // Window and its lower deassert edge, clamped to the legal span
  wire [12:0] win = (oof_cfg_in.win > WIN_MAX) ? WIN_MAX : oof_cfg_in.win;
  wire [12:0] win_lo = (win > oof_cfg_in.hyst) ? 13'(win - oof_cfg_in.hyst)
                                               : 13'h0;
  wire [24:0] win_w = {12'h000, win};
  wire [24:0] win_lo_w = {12'h000, win_lo};

  logic [N_IN-1:0] prec_bad;
  logic [N_IN-1:0] fast_bad;
  logic [N_IN-1:0] next_prec_bad;
  logic [N_IN-1:0] next_fast_bad;
  logic [24:0] prec_mag [N_IN];
  logic [24:0] fast_mag [N_IN];

  // Per input: relative offsets in 1/16 ppm and both monitor decisions
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      assign prec_mag[gi] = fm_mag(25'(prec_ofs_in[gi+1]) - 25'(ref_prec));
      assign fast_mag[gi] = fm_mag(25'(fast_ofs_in[gi+1]) - 25'(ref_fast));
      assign next_prec_bad[gi] = !oof_cfg_in.prec_en ? 1'b0 :
                                 !prec_stb_in ? prec_bad[gi] :
                                 (prec_mag[gi] > win_w) ? 1'b1 :
                                 (prec_mag[gi] <= win_lo_w) ? 1'b0 : prec_bad[gi];
      assign next_fast_bad[gi] = !oof_cfg_in.fast_en ? 1'b0 :
                                 !fast_stb_in ? fast_bad[gi] :
                                 (fast_mag[gi] > FAST_LIM);
    end
  endgenerate

  // Combined status: any enabled flag asserts, all clear to deassert
  wire [N_IN-1:0] next_oof = next_prec_bad | next_fast_bad;

  // Monitor flag registers
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      prec_bad <= '0;
      fast_bad <= '0;
      oof_live_out <= '0;
    end else begin
      prec_bad <= next_prec_bad;
      fast_bad <= next_fast_bad;
      oof_live_out <= next_oof;
    end
  end

  // Lock monitors share one delay time base
  logic tick;
  logic [N_LOOP-1:0] lol;
  fm_tick #(.CYC(TICK_CYC)) u_tick (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .tick_out(tick)
  );

  genvar gl;
  generate
    for (gl = 0; gl < N_LOOP; gl++) begin : g_loop
      fm_lol_mon u_lol (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .diff_in(lol_diff_in[gl]),
        .stb_in(lol_stb_in),
        .cfg_in(lol_cfg_in[gl]),
        .tick_in(tick),
        .lol_out(lol[gl])
      );
    end
  endgenerate

  // Sticky status: live level sets and beats any clear
  wire [N_IND-1:0] live = {lol, oof_live_out};
  wire [N_IND-1:0] clr = sticky_clr_stb_in ? sticky_clr_in : '0;
  wire [N_IND-1:0] next_sticky = live | (sticky_out & ~clr);
  wire next_irq_n = ~|(next_sticky & ~irq_mask_in);

  // Status, pins and interrupt registers
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      sticky_out <= STICKY_RST;
      lol_live_out <= '0;
      unlock_pin_loop_a_n_out <= 1'b1;
      unlock_pin_loop_c_n_out <= 1'b1;
      unlock_pin_loop_d_n_out <= 1'b1;
      unlock_pin_n_out <= 1'b1;
      irq_out_n <= 1'b1;
    end else begin
      sticky_out <= next_sticky;
      lol_live_out <= lol;
      unlock_pin_loop_a_n_out <= ~lol[0];
      unlock_pin_loop_c_n_out <= ~lol[1];
      unlock_pin_loop_d_n_out <= ~lol[2];
      unlock_pin_n_out <= ~lol[3];
      irq_out_n <= next_irq_n;
    end
  end

  // Crosspoint: stored routing loads once after reset, then host writes
  logic xpt_loaded;
  genvar gd;
  generate
    for (gd = 0; gd < N_DRV; gd++) begin : g_drv
      wire legal = (xpt_sel_in[gd] < XPT_LOOPS);
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          xpt_route_out[gd] <= XPT_RST;
        end else if (!xpt_loaded) begin
          xpt_route_out[gd] <= (xpt_nvm_in[gd] < XPT_LOOPS) ? xpt_nvm_in[gd]
                                                           : XPT_RST;
        end else if (xpt_wr_in && legal) begin
          xpt_route_out[gd] <= xpt_sel_in[gd];
        end
      end
    end
  endgenerate

  // Single-ended pair count, two pins per driver
  function automatic logic [3:0] fm_pop(input logic [N_DRV-1:0] v);
    fm_pop = 4'h0;
    for (int k = 0; k < N_DRV; k++) begin
      fm_pop = fm_pop + {3'h0, v[k]};
    end
  endfunction

  // Driver format and cascade; neighbour limit applies only when cascaded
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      xpt_loaded <= 1'b0;
      drv_se_out <= '0;
      se_pairs_out <= 4'h0;
      casc_1hz_out <= 1'b0;
      out5_over_out <= 1'b0;
    end else begin
      xpt_loaded <= 1'b1;
      drv_se_out <= drv_se_in;
      se_pairs_out <= fm_pop(drv_se_in);
      casc_1hz_out <= casc_1hz_in;
      out5_over_out <= casc_1hz_in && (out5_khz_in > OUT5_MAX_KHZ);
    end
  end

  property p_sticky_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      live[0] |=> sticky_out[0];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("sticky bit cleared while live condition stands");

  property p_sticky_clr;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (sticky_clr_stb_in && sticky_clr_in[6] && !lol[3]) |=> !sticky_out[6];
  endproperty
  a_sticky_clr: assert property (p_sticky_clr)
    else $error("sticky bit not cleared by host");

  property p_irq;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      $past(rstn_in) |-> (irq_out_n == ~|(sticky_out & ~$past(irq_mask_in)));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt pin disagrees with unmasked sticky bits");

  property p_irq_release;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (!irq_out_n && !sticky_clr_stb_in && $stable(irq_mask_in)) |=> !irq_out_n;
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("interrupt released with unmasked sticky bit set");

  property p_fast;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (fast_stb_in && oof_cfg_in.fast_en && fast_mag[0] > FAST_LIM)
        |=> ##1 oof_live_out[0];
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast monitor missed a large move");

  property p_prec_dis;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (!oof_cfg_in.prec_en && !oof_cfg_in.fast_en) |=> !oof_live_out[1];
  endproperty
  a_prec_dis: assert property (p_prec_dis)
    else $error("status raised with both monitors disabled");

  property p_pin;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      unlock_pin_loop_c_n_out == !lol_live_out[1];
  endproperty
  a_pin: assert property (p_pin)
    else $error("unlock pin does not follow live state");

  property p_limit;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (casc_1hz_in && out5_khz_in == 16'h82dd) |=> out5_over_out;
  endproperty
  a_limit: assert property (p_limit)
    else $error("neighbour limit not flagged");
endmodule

// >>> verilog/fm_pkg.sv
// Purpose: shared constants, types and helpers of the clock fault monitor
// Assumes: 10 MHz system clock; offsets in signed 1/16 ppm units
// Notes: lock differences are in 0.1 ppm units
package fm_pkg;
  // System clock
  localparam int CLK_PERIOD_NS = 100;
  // Clear-delay timer unit for the lock monitors
  localparam int LOL_TICK_NS = 1000000;
  localparam int LOL_TICK_CYC = (LOL_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Sizes
  localparam int N_IN = 3;
  localparam int N_SRC = 4;
  localparam int N_LOOP = 4;
  localparam int N_IND = 7;
  localparam int N_DRV = 7;
  localparam int OFS_W = 24;
  localparam int LOL_W = 17;
  // Frequency limits: 500 ppm and 4000 ppm in 1/16 ppm steps
  localparam logic [12:0] WIN_MAX = 13'h1f40;
  localparam logic [24:0] FAST_LIM = 25'h000fa00;
  // Lock threshold range: 0.1 ppm to 10000 ppm in 0.1 ppm steps
  localparam logic [LOL_W-1:0] LOL_THR_MIN = 17'h00001;
  localparam logic [LOL_W-1:0] LOL_THR_MAX = 17'h186a0;
  // Neighbour output ceiling in cascade mode, kHz
  localparam logic [15:0] OUT5_MAX_KHZ = 16'h82dc;
  // Reset values
  localparam logic [N_IND-1:0] STICKY_RST = 7'h00;
  localparam logic LOL_RST = 1'b1;
  localparam logic [1:0] XPT_RST = 2'h0;
  localparam logic [1:0] XPT_LOOPS = 2'h3;

  // Zero-ppm reference choice
  typedef enum logic [2:0] {
    FM_REF_PIN,
    FM_REF_IN0,
    FM_REF_IN1,
    FM_REF_IN2,
    FM_REF_XTAL
  } fm_ref_sel_t;

  // Frequency monitor configuration
  typedef struct packed {
    logic prec_en;
    logic fast_en;
    logic [12:0] win;
    logic [12:0] hyst;
    fm_ref_sel_t ref_sel;
  } fm_oof_cfg_t;

  // Lock monitor configuration for one loop
  typedef struct packed {
    logic [LOL_W-1:0] set_thr;
    logic [LOL_W-1:0] clr_thr;
    logic dly_en;
    logic [15:0] dly_ms;
  } fm_lol_cfg_t;

  // Magnitude of a signed relative offset
  function automatic logic [24:0] fm_mag(input logic signed [24:0] v);
    fm_mag = v[24] ? 25'(-v) : 25'(v);
  endfunction

  // Keep a lock threshold inside its legal range
  function automatic logic [LOL_W-1:0] fm_lol_clamp(input logic [LOL_W-1:0] t);
    if (t < LOL_THR_MIN) begin
      fm_lol_clamp = LOL_THR_MIN;
    end else if (t > LOL_THR_MAX) begin
      fm_lol_clamp = LOL_THR_MAX;
    end else begin
      fm_lol_clamp = t;
    end
  endfunction
endpackage

// >>> verilog/fm_tick.sv
// Purpose: divider giving a one-cycle enable per clear-delay time unit
// Assumes: single system clock
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/1ps
module fm_tick #(
  parameter int CYC = 10000
) (
  input logic clk_sys_in,   // System clock
  input logic rstn_in,      // Synchronous reset, active low
  output logic tick_out     // One-cycle enable
);
  import fm_pkg::*;
  logic [31:0] cnt;
  wire wrap = (cnt == 32'(CYC - 1));

  // Free-running divider
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cnt <= 32'h0;
      tick_out <= 1'b0;
    end else begin
      cnt <= wrap ? 32'h0 : cnt + 32'h1;
      tick_out <= wrap;
    end
  end
endmodule
